// ===== cal_host_pkg.sv
package cal_host_pkg;
	localparam int          ADDR_W         = 17;
	localparam int          DATA_W         = 8;
	localparam int          PAT_BITS       = 64;
	localparam int          CAL_REGS       = 8;
	localparam int          CAL_BITS       = 64;
	localparam logic [63:0] UNLOCK_PATTERN = 64'h5ca3_3ac5_5ca3_3ac5;
	localparam int          DAY_REG        = 4;
	localparam int          RESET_EN_BIT   = 4;
	localparam int          OSC_STOP_BIT   = 5;
	localparam int          SETUP_NS       = 20;
	localparam int          STROBE_NS      = 100;
	localparam int          RECOVER_NS     = 20;
	localparam int          CLK_NS         = 5;
	localparam logic [7:0]  SETUP_CYC      = 8'((SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0]  STROBE_CYC     = 8'((STROBE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0]  RECOVER_CYC    = 8'((RECOVER_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [16:0] SCRATCH_ADDR   = 17'h1_ffff;
endpackage : cal_host_pkg

// ===== cal_buf2.sv
`timescale 1ns/100ps
module cal_buf2 (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic [63:0] in_data,
	input  wire logic        in_valid,
	output logic             in_ready,
	output logic      [63:0] out_data,
	output logic             out_valid,
	input  wire logic        out_ready
);
	logic [63:0] head;
	logic        head_valid;
	logic [63:0] spare;
	logic        spare_valid;
	logic [63:0] next_head;
	logic        next_head_valid;
	logic [63:0] next_spare;
	logic        next_spare_valid;
	logic        push;
	logic        pop;

	// outputs come from the head register; the spare catches a word during a stall
	always_comb begin
		push             = in_valid && !spare_valid;
		pop              = out_ready && head_valid;
		next_head        = head;
		next_head_valid  = head_valid;
		next_spare       = spare;
		next_spare_valid = spare_valid;
		if (!head_valid || pop) begin
			if (spare_valid) begin
				next_head        = spare;
				next_head_valid  = 1'b1;
				next_spare_valid = 1'b0;
			end else if (push) begin
				next_head       = in_data;
				next_head_valid = 1'b1;
			end else begin
				next_head_valid = 1'b0;
			end
		end else if (push) begin
			next_spare       = in_data;
			next_spare_valid = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			head        <= 64'h0000_0000_0000_0000;
			head_valid  <= 1'b0;
			spare       <= 64'h0000_0000_0000_0000;
			spare_valid <= 1'b0;
		end else begin
			head        <= next_head;
			head_valid  <= next_head_valid;
			spare       <= next_spare;
			spare_valid <= next_spare_valid;
		end
	end

	assign in_ready  = !spare_valid;
	assign out_valid = head_valid;
	assign out_data  = head;
endmodule : cal_buf2

// ===== cal_host.sv
`timescale 1ns/100ps
module cal_host (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        cmd_valid,
	input  wire logic        cmd_write,
	input  wire logic [63:0] cmd_data,
	output logic             cmd_ready,
	output logic      [63:0] rsp_data,
	output logic             rsp_valid,
	input  wire logic        rsp_ready,
	input  wire logic        power_fail_threshold,
	output logic      [16:0] addr_lines,
	output logic             chip_sel_n,
	output logic             out_gate_n,
	output logic             wr_strobe_n,
	output logic      [7:0]  data_out,
	output logic             data_oe,
	input  wire logic        data_line_lsb,
	output logic             busy,
	output logic             aborted
);
	typedef enum {IDLE, SETUP, STROBE, RECOVER, NEXT} state_t;
	typedef enum {PH_START, PH_MATCH, PH_XFER} phase_t;

	state_t      state;
	state_t      next_state;
	phase_t      phase;
	phase_t      next_phase;
	logic [7:0]  tmr;
	logic [7:0]  next_tmr;
	logic [6:0]  idx;
	logic [6:0]  next_idx;
	logic        wr;
	logic        next_wr;
	logic [63:0] shreg;
	logic [63:0] next_shreg;
	logic        pf_s1;
	logic        pf_s2;
	logic        dq_s1;
	logic        dq_s2;
	logic        next_cs_n;
	logic        next_oe_n;
	logic        next_we_n;
	logic [7:0]  next_dout;
	logic        next_doe;
	logic        next_busy;
	logic        next_aborted;
	logic        next_cmd_ready;
	logic        buf_in_valid;
	logic        buf_in_ready;

	function automatic logic [7:0] ns_cycles(input logic [7:0] c);
		ns_cycles = (c == 8'h00) ? 8'h01 : c;
	endfunction : ns_cycles

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pf_s1 <= 1'b1;
			pf_s2 <= 1'b1;
			dq_s1 <= 1'b0;
			dq_s2 <= 1'b0;
		end else begin
			pf_s1 <= power_fail_threshold;
			pf_s2 <= pf_s1;
			dq_s1 <= data_line_lsb;
			dq_s2 <= dq_s1;
		end
	end

	always_comb begin
		next_state   = state;
		next_phase   = phase;
		next_tmr     = tmr;
		next_idx     = idx;
		next_wr      = wr;
		next_shreg   = shreg;
		next_cs_n    = chip_sel_n;
		next_oe_n    = out_gate_n;
		next_we_n    = wr_strobe_n;
		next_dout    = data_out;
		next_doe     = data_oe;
		next_busy    = busy;
		next_aborted = aborted;
		buf_in_valid = 1'b0;
		case (state)
			IDLE: begin
				if (cmd_valid && cmd_ready) begin
					next_busy    = 1'b1;
					next_aborted = 1'b0;
					next_wr      = cmd_write;
					next_shreg   = cmd_data;
					next_phase   = PH_START;
					next_idx     = 7'h00;
					next_tmr     = ns_cycles(cal_host_pkg::SETUP_CYC);
					next_state   = SETUP;
				end
			end
			SETUP: begin
				// address already stable; strobes low together
				if (pf_s2) begin
					next_aborted = 1'b1;
					next_state   = RECOVER;
				end else if (tmr > 8'h01) begin
					next_tmr = 8'(tmr - 8'h01);
				end else begin
					next_cs_n = 1'b0;
					next_tmr  = ns_cycles(cal_host_pkg::STROBE_CYC);
					next_state = STROBE;
					if (phase == PH_START || (phase == PH_XFER && !wr)) begin
						next_oe_n = 1'b0;
					end else begin
						next_we_n = 1'b0;
						next_doe  = 1'b1;
						if (phase == PH_MATCH) begin
							next_dout = {7'h00, cal_host_pkg::UNLOCK_PATTERN[6'(idx)]};
						end else begin
							next_dout = {7'h00, shreg[0]};
						end
					end
				end
			end
			STROBE: begin
				if (tmr > 8'h01) begin
					next_tmr = 8'(tmr - 8'h01);
				end else begin
					if (phase == PH_XFER && !wr) begin
						next_shreg = {dq_s2, shreg[63:1]};
					end else if (phase == PH_XFER) begin
						next_shreg = {1'b0, shreg[63:1]};
					end
					next_cs_n  = 1'b1;
					next_oe_n  = 1'b1;
					next_we_n  = 1'b1;
					next_doe   = 1'b0;
					next_tmr   = ns_cycles(cal_host_pkg::RECOVER_CYC);
					next_state = RECOVER;
				end
			end
			RECOVER: begin
				if (tmr > 8'h01) begin
					next_tmr = 8'(tmr - 8'h01);
				end else begin
					next_state = NEXT;
				end
			end
			NEXT: begin
				if (aborted) begin
					next_busy  = 1'b0;
					next_state = IDLE;
				end else if (phase == PH_START) begin
					next_phase = PH_MATCH;
					next_idx   = 7'h00;
					next_tmr   = ns_cycles(cal_host_pkg::SETUP_CYC);
					next_state = SETUP;
				end else if (idx != 7'(cal_host_pkg::PAT_BITS - 1) || phase == PH_MATCH) begin
					if (phase == PH_MATCH && idx == 7'(cal_host_pkg::PAT_BITS - 1)) begin
						next_phase = PH_XFER;
						next_idx   = 7'h00;
					end else begin
						next_idx = 7'(idx + 7'h01);
					end
					next_tmr   = ns_cycles(cal_host_pkg::SETUP_CYC);
					next_state = SETUP;
				end else if (wr || buf_in_ready) begin
					buf_in_valid = !wr;
					next_busy    = 1'b0;
					next_state   = IDLE;
				end
			end
			default: next_state = IDLE;
		endcase
		next_cmd_ready = (next_state == IDLE) && !pf_s2;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state       <= IDLE;
			phase       <= PH_START;
			tmr         <= 8'h00;
			idx         <= 7'h00;
			wr          <= 1'b0;
			shreg       <= 64'h0000_0000_0000_0000;
			chip_sel_n  <= 1'b1;
			out_gate_n  <= 1'b1;
			wr_strobe_n <= 1'b1;
			data_out    <= 8'h00;
			data_oe     <= 1'b0;
			busy        <= 1'b0;
			aborted     <= 1'b0;
			addr_lines  <= 17'h0_0000;
			cmd_ready   <= 1'b0;
		end else begin
			state       <= next_state;
			phase       <= next_phase;
			tmr         <= next_tmr;
			idx         <= next_idx;
			wr          <= next_wr;
			shreg       <= next_shreg;
			chip_sel_n  <= next_cs_n;
			out_gate_n  <= next_oe_n;
			wr_strobe_n <= next_we_n;
			data_out    <= next_dout;
			data_oe     <= next_doe;
			busy        <= next_busy;
			aborted     <= next_aborted;
			addr_lines  <= cal_host_pkg::SCRATCH_ADDR;
			cmd_ready   <= next_cmd_ready;
		end
	end

	cal_buf2 u_buf (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.in_data   (next_shreg),
		.in_valid  (buf_in_valid),
		.in_ready  (buf_in_ready),
		.out_data  (rsp_data),
		.out_valid (rsp_valid),
		.out_ready (rsp_ready)
	);
endmodule : cal_host

// ===== cal_host_assertions.sv
`timescale 1ns/100ps
module cal_host_assertions (
	input wire logic        sys_clk,
	input wire logic        rstn,
	input wire logic        cmd_ready,
	input wire logic        busy,
	input wire logic        power_fail_threshold,
	input wire logic [16:0] addr_lines,
	input wire logic        chip_sel_n,
	input wire logic        out_gate_n,
	input wire logic        wr_strobe_n,
	input wire logic [7:0]  data_out,
	input wire logic        data_oe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic [6:0] wcnt;
	// finished write strobes within one command
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			wcnt <= 7'h00;
		else if (!busy)
			wcnt <= 7'h00;
		else if ($rose(wr_strobe_n) && wcnt < 7'h40)
			wcnt <= wcnt + 7'h01;
	end
	chk_gate_wr_excl: assert property (out_gate_n || wr_strobe_n)
		else $error("gate and strobe both low");
	chk_oe_window: assert property (data_oe == !wr_strobe_n)
		else $error("drive outside write strobe");
	chk_addr_hold: assert property (!wr_strobe_n |-> $stable(addr_lines))
		else $error("address moved in write");
	chk_scratch_addr: assert property (
		!chip_sel_n |-> addr_lines == cal_host_pkg::SCRATCH_ADDR)
		else $error("not the scratch address");
	chk_strobe_len: assert property (
		$fell(chip_sel_n) |-> ##19 !chip_sel_n ##1 chip_sel_n)
		else $error("strobe length wrong");
	chk_wr_in_sel: assert property (!wr_strobe_n |-> !chip_sel_n)
		else $error("write strobe without select");
	// ready is registered after the two synchroniser stages
	chk_pf_ready: assert property (power_fail_threshold [*4] |-> !cmd_ready)
		else $error("ready during power fail");
	chk_pf_nostart: assert property (power_fail_threshold [*8] |-> !$fell(chip_sel_n))
		else $error("cycle started in power fail");
	chk_read_first: assert property (
		$rose(busy) |-> ##[0:10] ($fell(chip_sel_n) && !out_gate_n))
		else $error("command does not open with read");
	chk_pattern_bit: assert property (
		!wr_strobe_n && wcnt < 7'h40
		|-> data_out == {7'h00, cal_host_pkg::UNLOCK_PATTERN[wcnt[5:0]]})
		else $error("unlock bit wrong");
endmodule : cal_host_assertions
bind cal_host cal_host_assertions chk (.*);

// ===== cal_dev_model.sv
`timescale 1ns/100ps
module cal_dev_model (
	input wire logic       chip_sel_n,
	input wire logic       out_gate_n,
	input wire logic       wr_strobe_n,
	input wire logic [7:0] data_out,
	input wire logic       power_fail_threshold,
	output logic           data_line_lsb
);
	logic [63:0] cal = 64'h0000_0000_0000_0000;
	logic [6:0]  ptr = 7'h00;
	logic [6:0]  cnt = 7'h00;
	logic        armed = 1'b0;
	logic        unlocked = 1'b0;
	logic        was_wr = 1'b0;
	int          mem_wr = 0;
	logic        osc_stopped;
	logic        reset_honoured;
	localparam int OSC_POS = cal_host_pkg::DAY_REG * 8 + cal_host_pkg::OSC_STOP_BIT;
	localparam int RST_POS = cal_host_pkg::DAY_REG * 8 + cal_host_pkg::RESET_EN_BIT;
	// write spans the overlap of select and strobe
	always @(negedge wr_strobe_n or negedge chip_sel_n) begin
		if (!chip_sel_n && !wr_strobe_n)
			was_wr = 1'b1;
	end
	always @(posedge chip_sel_n) begin
		if (!power_fail_threshold) begin
			if (unlocked) begin
				if (was_wr)
					cal[cnt[5:0]] = data_out[0];
				cnt = cnt + 7'h01;
				unlocked = (cnt != 7'h40);
			end else if (!was_wr) begin
				ptr = 7'h00;
				armed = 1'b1;
			end else begin
				mem_wr = mem_wr + 1;
				if (armed && data_out[0] == cal_host_pkg::UNLOCK_PATTERN[ptr[5:0]])
					ptr = ptr + 7'h01;
				else
					armed = 1'b0;
				unlocked = (ptr == 7'h40);
				cnt = 7'h00;
				ptr = unlocked ? 7'h00 : ptr;
			end
		end
		was_wr = 1'b0;
	end
	// undriven line shows the inverse of the bit
	assign data_line_lsb = (!chip_sel_n && !out_gate_n && wr_strobe_n && unlocked)
		? cal[cnt[5:0]] : ~cal[cnt[5:0]];
	// control bits of the day register
	assign osc_stopped    = cal[OSC_POS];
	assign reset_honoured = !cal[RST_POS];
endmodule : cal_dev_model

// ===== cal_host_test.sv
`timescale 1ns/100ps
module cal_host_test;
	localparam logic [63:0] IMG = 64'h9906_2813_1231_5945;
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        cmd_valid = 1'b0;
	logic        cmd_write = 1'b0;
	logic [63:0] cmd_data = 64'h0000_0000_0000_0000;
	logic        rsp_ready = 1'b0;
	logic        power_fail_threshold = 1'b0;
	logic        cmd_ready, rsp_valid, busy, aborted, data_line_lsb;
	logic        chip_sel_n, out_gate_n, wr_strobe_n, data_oe;
	logic [63:0] rsp_data;
	logic [16:0] addr_lines;
	logic [7:0]  data_out;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	cal_host dut (.*);
	cal_dev_model far_end (.*);
	always #2.5 sys_clk = ~sys_clk;
	task automatic print_verdict();
		if (n_fail == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 30000) begin
			n_fail++;
			print_verdict();
		end
	end
	task automatic check(input logic ok, input string what);
		samples_checked++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("ERROR %0t %s", $time, what);
		end
	endtask : check
	task automatic issue(input logic w, input logic [63:0] d);
		cmd_write <= w;
		cmd_data <= d;
		cmd_valid <= 1'b1;
		@(posedge sys_clk);
		while (cmd_ready !== 1'b1) @(posedge sys_clk);
		cmd_valid <= 1'b0;
		@(posedge sys_clk);
		while (busy === 1'b1) @(posedge sys_clk);
	endtask : issue
	task automatic t_write();
		issue(1'b1, IMG);
		check(far_end.cal === IMG, "calendar image");
		check(far_end.mem_wr == 64, "array writes");
		check(far_end.unlocked === 1'b0, "still unlocked");
		check(aborted === 1'b0, "abort flag");
		check(far_end.osc_stopped === 1'b0, "oscillator stopped");
		check(far_end.reset_honoured === 1'b0, "reset pin honoured");
	endtask : t_write
	task automatic t_read_stall();
		issue(1'b0, 64'h0000_0000_0000_0000);
		issue(1'b0, 64'h0000_0000_0000_0000);
		check(rsp_valid === 1'b1, "buffer empty");
		check(far_end.mem_wr == 192, "array writes");
		rsp_ready <= 1'b1;
		@(posedge sys_clk);
		check(rsp_data === IMG, "first read");
		@(posedge sys_clk);
		check(rsp_data === IMG, "second read");
		@(posedge sys_clk);
		check(rsp_valid === 1'b0, "buffer not drained");
	endtask : t_read_stall
	task automatic t_power_fail();
		power_fail_threshold <= 1'b1;
		repeat (4) @(posedge sys_clk);
		check(cmd_ready === 1'b0, "ready in power fail");
		power_fail_threshold <= 1'b0;
		fork
			issue(1'b1, 64'h0000_0000_0000_0000);
			begin
				repeat (300) @(posedge sys_clk);
				power_fail_threshold <= 1'b1;
			end
		join
		check(aborted === 1'b1, "no abort");
		check(far_end.cal === IMG, "calendar altered");
		power_fail_threshold <= 1'b0;
		rsp_ready <= 1'b0;
		issue(1'b0, 64'h0000_0000_0000_0000);
		check(rsp_data === IMG && rsp_valid === 1'b1, "read after abort");
		check(aborted === 1'b0, "abort not cleared");
	endtask : t_power_fail
	initial begin
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		t_write();
		t_read_stall();
		t_power_fail();
		print_verdict();
	end
endmodule : cal_host_test
